// File: design/gcta_pkg.sv
package gcta_pkg;

  // ==========================================================================
  // Sizes
  localparam int NFR    = 4;            // Framers served
  localparam int CNT_W  = 16;           // Width of one shadowed counter
  localparam int WPF    = 4;            // Shadow words per framer
  localparam int NSH    = NFR * WPF;    // All shadow words
  localparam int SH_AW  = $clog2(NSH);
  localparam int IR_W   = 4;
  localparam int BSR_W  = NFR * 3;      // Clock and two rails per framer
  localparam int NEV    = 3;

  // ==========================================================================
  // Register word indices, byte address is four times the index
  localparam logic [9:0] IDX_PM     = 10'h006;
  localparam logic [9:0] IDX_PRBS   = 10'h013;
  localparam logic [9:0] IDX_STAT   = 10'h020;
  localparam logic [9:0] IDX_MASK   = 10'h021;
  localparam logic [9:0] IDX_PINS   = 10'h022;
  localparam logic [9:0] IDX_SHADOW = 10'h040;
  localparam logic [9:0] NSH_IDX    = 10'(NSH);
  localparam logic [11:0] ADDR_PM   = {IDX_PM, 2'b00};
  localparam logic [11:0] ADDR_PRBS = {IDX_PRBS, 2'b00};
  localparam logic [11:0] ADDR_STAT = {IDX_STAT, 2'b00};

  // Field positions
  localparam int SHADOW_EN_BIT = 3;
  localparam int PRBS_EN_BIT   = 5;
  localparam int EV_SHADOW     = 0;
  localparam int EV_LOCK_LOST  = 1;
  localparam int EV_TAP_ACTIVE = 2;

  // Synchroniser slots for pins
  localparam int SY_SEC  = 0;
  localparam int SY_CFG1 = 1;
  localparam int SY_CFG2 = 2;
  localparam int SY_PD   = 3;
  localparam int SY_FLT  = 4;
  localparam int SY_SCAN = 5;
  localparam int SY_TCK  = 6;
  localparam int SY_TMS  = 7;
  localparam int SY_TDI  = 8;
  localparam int NSY     = 9;

  // Test port instruction codes, capture pattern and reset run length
  localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS  = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [2:0]      TMS_RESET_RUN = 3'h5;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
  } gcta_tx_t;

  typedef enum {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } gcta_tap_state_t;

  typedef struct packed {
    gcta_tap_state_t   st;
    logic [IR_W-1:0]   ir;
    logic [IR_W-1:0]   ir_sh;
    logic              bypass;
    logic [BSR_W-1:0]  bsr_sh;
    logic [BSR_W-1:0]  bsr_upd;
    logic              extest;
    logic              tdo;
    logic              tdo_oe;
    logic              in_reset;
    logic [2:0]        tms_run;
  } gcta_tap_reg_t;

  typedef struct packed {
    logic [NSY-1:0]                sync1;
    logic [NSY-1:0]                sync2;
    logic                          sec_d;
    logic                          tck_d;
    logic                          shadow_enable;
    logic                          prbs_enable;
    logic [NEV-1:0]                status;
    logic [NEV-1:0]                mask;
    logic                          tap_reset_d;
    logic [NSH-1:0][CNT_W-1:0]     shadow;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic                          irq;
    gcta_tx_t [NFR-1:0]            tx_out;
    logic                          line_ctl_en;
    logic                          monitor_en;
    logic                          transmission_mode;
    logic                          pins_oe;
    logic                          out_of_lock;
    logic                          loop_tick;
  } gcta_reg_t;

endpackage : gcta_pkg

// File: design/gcta_tap.sv
`timescale 1ns/1ps
module gcta_tap (
  // Clock and resets
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        test_port_reset_n,
  // Sampled test port
  input  wire logic                        tck_rise,
  input  wire logic                        tck_fall,
  input  wire logic                        tms,
  input  wire logic                        tdi,
  // Boundary cells
  input  wire logic [gcta_pkg::BSR_W-1:0]  bsr_capture,
  output logic      [gcta_pkg::BSR_W-1:0]  bsr_update,
  output logic                             extest_active,
  output logic                             in_reset,
  // Serial out
  output logic                             tdo,
  output logic                             tdo_oe
);
  import gcta_pkg::*;

  gcta_tap_reg_t   r;
  gcta_tap_reg_t   n;
  gcta_tap_state_t ns;
  logic            bsr_sel;

  // ==========================================================================
  // Controller
  // Standard walk, stepped only on a sampled rising test clock
  always_comb begin
    n       = r;
    bsr_sel = (r.ir == IR_EXTEST) || (r.ir == IR_SAMPLE);
    case (r.st)
      TLR:     ns = tms ? TLR    : RTI;
      RTI:     ns = tms ? SEL_DR : RTI;
      SEL_DR:  ns = tms ? SEL_IR : CAP_DR;
      CAP_DR:  ns = tms ? EX1_DR : SH_DR;
      SH_DR:   ns = tms ? EX1_DR : SH_DR;
      EX1_DR:  ns = tms ? UPD_DR : PA_DR;
      PA_DR:   ns = tms ? EX2_DR : PA_DR;
      EX2_DR:  ns = tms ? UPD_DR : SH_DR;
      UPD_DR:  ns = tms ? SEL_DR : RTI;
      SEL_IR:  ns = tms ? TLR    : CAP_IR;
      CAP_IR:  ns = tms ? EX1_IR : SH_IR;
      SH_IR:   ns = tms ? EX1_IR : SH_IR;
      EX1_IR:  ns = tms ? UPD_IR : PA_IR;
      PA_IR:   ns = tms ? EX2_IR : PA_IR;
      EX2_IR:  ns = tms ? UPD_IR : SH_IR;
      UPD_IR:  ns = tms ? SEL_DR : RTI;
      default: ns = TLR;
    endcase
    if (tck_rise) begin
      case (r.st)
        TLR: begin
          n.ir     = IR_BYPASS;
          n.extest = 1'b0;
        end
        CAP_IR:  n.ir_sh = IR_CAPTURE;
        SH_IR:   n.ir_sh = {tdi, r.ir_sh[IR_W-1:1]};
        UPD_IR: begin
          n.ir     = r.ir_sh;
          n.extest = (r.ir_sh == IR_EXTEST);
        end
        CAP_DR: begin
          n.bypass = 1'b0;
          if (bsr_sel) begin
            n.bsr_sh = bsr_capture;
          end
        end
        SH_DR: begin
          n.bypass = tdi;
          if (bsr_sel) begin
            n.bsr_sh = {tdi, r.bsr_sh[BSR_W-1:1]};
          end
        end
        UPD_DR: begin
          if (bsr_sel) begin
            n.bsr_upd = r.bsr_sh;
          end
        end
        default: n.ir_sh = r.ir_sh;
      endcase
      n.st       = ns;
      n.in_reset = (ns == TLR);
      n.tms_run  = !tms ? 3'h0 : (r.tms_run == TMS_RESET_RUN) ? r.tms_run : r.tms_run + 3'h1;
    end
    // Output changes only on a falling edge, floats outside shifting
    if (tck_fall) begin
      n.tdo_oe = (r.st == SH_IR) || (r.st == SH_DR);
      if (r.st == SH_IR) begin
        n.tdo = r.ir_sh[0];
      end else if (r.st == SH_DR) begin
        n.tdo = bsr_sel ? r.bsr_sh[0] : r.bypass;
      end else begin
        n.tdo = 1'b0;
      end
    end
  end

  // Either reset puts the controller back in test logic reset at once
  always_ff @(posedge pclk or negedge presetn or negedge test_port_reset_n) begin
    if (!presetn || !test_port_reset_n) begin
      r          <= '0;
      r.st       <= TLR;
      r.ir       <= IR_BYPASS;
      r.in_reset <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign bsr_update    = r.bsr_upd;
  assign extest_active = r.extest;
  assign in_reset      = r.in_reset;
  assign tdo           = r.tdo;
  assign tdo_oe        = r.tdo_oe;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  tdo_edge_a: assert property (disable iff (!presetn || !test_port_reset_n)
      $changed(tdo) |-> $past(tck_fall))
    else $error("test data out moved away from a falling edge");
  tms_reset_a: assert property (r.tms_run == TMS_RESET_RUN |-> r.st == TLR)
    else $error("five high mode selects did not reset the controller");
  tdo_float_a: assert property ($rose(tdo_oe) |-> (r.st == SH_IR || r.st == SH_DR))
    else $error("test data out driven outside a shift state");
  trst_hold_a: assert property (!test_port_reset_n |-> r.st == TLR && in_reset)
    else $error("test reset did not hold the controller in reset");
  bypass_cap_a: assert property (tck_rise && r.st == CAP_DR |=> !r.bypass)
    else $error("bypass cell did not capture zero");
endmodule : gcta_tap

// File: design/gcta_top.sv
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Contract
// - Strobe rise with shadowing on copies counters and monitor words to shadows
// - Counters run without strobe; no shadow copy then
// - Shadowing enabled by bit 3 of register 006H
// - Loop code detection runs only on strobe ticks
// - Select low enables line control; high makes monitor interface
// - Select low gives Transmission Mode; high gives MVIP Mode; all framers
// - Power down low forces transmit clock and rails of all framers low; under extest the boundary cells drive them instead
// - Out-of-lock pin only in Transmission Mode with bit 5 of 013H set
// - Enabled out-of-lock pin high while analyzer unlocked, low when locked
// - Float input low floats all outputs except test data out
// - Test data in sampled on rising, out changed on falling; clock up to 10 MHz
// - Mode select sampled on rising edges steps the standard controller
// - Test data out floats unless shifting
// - Test reset low resets controller asynchronously; pulse at least 10 ns
module gcta_top (
  // Clock and reset
  input  wire logic                                             pclk,
  input  wire logic                                             presetn,
  // Register bus
  input  wire logic                                             psel,
  input  wire logic                                             penable,
  input  wire logic                                             pwrite,
  input  wire logic [11:0]                                      paddr,
  input  wire logic [31:0]                                      pwdata,
  output logic      [31:0]                                      prdata,
  output logic                                                  pready,
  output logic                                                  pslverr,
  output logic                                                  irq,
  // Board pins
  input  wire logic                                             one_second_strobe,
  input  wire logic                                             system_mode_select,
  input  wire logic                                             line_control_select,
  input  wire logic                                             protection_power_down_n,
  input  wire logic                                             global_float_n,
  input  wire logic                                             factory_scan_enable,
  // Framer datapath
  input  wire logic [gcta_pkg::NSH-1:0][gcta_pkg::CNT_W-1:0]    live_counts,
  input  wire logic                                             analyzer_in_lock,
  input  wire gcta_pkg::gcta_tx_t [gcta_pkg::NFR-1:0]           tx_in,
  // Chip controls
  output gcta_pkg::gcta_tx_t [gcta_pkg::NFR-1:0]                tx_out,
  output logic                                                  line_control_enable,
  output logic                                                  monitor_enable,
  output logic                                                  transmission_mode,
  output logic                                                  pattern_out_of_lock,
  output logic                                                  loop_detect_tick,
  output logic                                                  output_enable,
  // Test port
  input  wire logic                                             tck,
  input  wire logic                                             tms,
  input  wire logic                                             tdi,
  input  wire logic                                             test_port_reset_n,
  output logic                                                  tdo,
  output logic                                                  tdo_oe
);
  import gcta_pkg::*;

  gcta_reg_t             r;
  gcta_reg_t             n;
  logic [NSY-1:0]        pin_v;
  logic                  sec_rise;
  logic                  tck_rise;
  logic                  tck_fall;
  logic                  wr;
  logic                  setup;
  logic [9:0]            idx;
  logic [9:0]            sh_off;
  logic [NEV-1:0]        ev;
  logic [BSR_W-1:0]      bsr_update;
  logic                  extest_active;
  logic                  tap_in_reset;

  // ==========================================================================
  // Pin sampling
  // Every pin from outside the clock domain except the test reset gets two flops first
  always_comb begin
    pin_v          = '0;
    pin_v[SY_SEC]  = one_second_strobe;
    pin_v[SY_CFG1] = system_mode_select;
    pin_v[SY_CFG2] = line_control_select;
    pin_v[SY_PD]   = protection_power_down_n;
    pin_v[SY_FLT]  = global_float_n;
    pin_v[SY_SCAN] = factory_scan_enable;
    pin_v[SY_TCK]  = tck;
    pin_v[SY_TMS]  = tms;
    pin_v[SY_TDI]  = tdi;
  end

  // Edge detection reads only the second stage
  assign sec_rise = r.sync2[SY_SEC] & ~r.sec_d;
  assign tck_rise = r.sync2[SY_TCK] & ~r.tck_d;
  assign tck_fall = ~r.sync2[SY_TCK] & r.tck_d;

  // ==========================================================================
  // Bus decode
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & r.pready & pwrite & ~r.pslverr;
  assign idx    = paddr[11:2];
  assign sh_off = idx - IDX_SHADOW;

  // ==========================================================================
  // Test access port
  gcta_tap u_tap (
    .pclk              (pclk),
    .presetn           (presetn),
    .test_port_reset_n (test_port_reset_n),
    .tck_rise          (tck_rise),
    .tck_fall          (tck_fall),
    .tms               (r.sync2[SY_TMS]),
    .tdi               (r.sync2[SY_TDI]),
    .bsr_capture       (BSR_W'(tx_in)),
    .bsr_update        (bsr_update),
    .extest_active     (extest_active),
    .in_reset          (tap_in_reset),
    .tdo               (tdo),
    .tdo_oe            (tdo_oe)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    n             = r;
    n.sync1       = pin_v;
    n.sync2       = r.sync1;
    n.sec_d       = r.sync2[SY_SEC];
    n.tck_d       = r.sync2[SY_TCK];
    n.tap_reset_d = tap_in_reset;

    // Shadow copy on strobe rise only; live counts keep running outside
    if (sec_rise && r.shadow_enable) begin
      n.shadow = live_counts;
    end

    // Loop code detector is clocked by the strobe tick alone
    n.loop_tick = sec_rise;

    // Static selects, common to all framers
    n.line_ctl_en       = ~r.sync2[SY_CFG2];
    n.monitor_en        = r.sync2[SY_CFG2];
    n.transmission_mode = ~r.sync2[SY_CFG1];

    // Out of lock only reported when gated in
    n.out_of_lock = ~r.sync2[SY_CFG1] & r.prbs_enable & ~analyzer_in_lock;

    // Float everything but test data out while the float pin is low
    n.pins_oe = r.sync2[SY_FLT];

    // Extest owns the transmit pins; power down overrides normal data
    if (extest_active) begin
      n.tx_out = bsr_update;
    end else if (!r.sync2[SY_PD]) begin
      n.tx_out = '0;
    end else begin
      n.tx_out = tx_in;
    end

    // Events
    ev                = '0;
    ev[EV_SHADOW]     = sec_rise & r.shadow_enable;
    ev[EV_LOCK_LOST]  = n.out_of_lock & ~r.out_of_lock;
    ev[EV_TAP_ACTIVE] = r.tap_reset_d & ~tap_in_reset;

    // Register writes land on the access edge with pready high
    if (wr && idx == IDX_PM) begin
      n.shadow_enable = pwdata[SHADOW_EN_BIT];
    end
    if (wr && idx == IDX_PRBS) begin
      n.prbs_enable = pwdata[PRBS_EN_BIT];
    end
    if (wr && idx == IDX_MASK) begin
      n.mask = pwdata[NEV-1:0];
    end
    // A new event beats a clear in the same cycle
    if (wr && idx == IDX_STAT) begin
      n.status = r.status & ~pwdata[NEV-1:0];
    end
    n.status = n.status | ev;
    n.irq    = |(n.status & n.mask);

    // No wait state: data and pready built in the setup cycle
    n.pready  = setup;
    n.pslverr = 1'b0;
    n.prdata  = '0;
    if (setup) begin
      if (paddr[1:0] != 2'b00) begin
        n.pslverr = 1'b1;
      end else if (idx >= IDX_SHADOW && sh_off < NSH_IDX) begin
        n.prdata = 32'(r.shadow[sh_off[SH_AW-1:0]]);
      end else begin
        case (idx)
          IDX_PM:   n.prdata[SHADOW_EN_BIT] = r.shadow_enable;
          IDX_PRBS: n.prdata[PRBS_EN_BIT]   = r.prbs_enable;
          IDX_STAT: n.prdata                = 32'(r.status);
          IDX_MASK: n.prdata                = 32'(r.mask);
          IDX_PINS: n.prdata = 32'({extest_active, tap_in_reset, analyzer_in_lock, r.sync2[SY_SCAN:SY_CFG1]});
          default:  n.pslverr               = 1'b1;
        endcase
      end
    end
  end

  // ==========================================================================
  // State register
  // Pins reset to a safe state: line control and monitor off, outputs floating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  assign prdata              = r.prdata;
  assign pready              = r.pready;
  assign pslverr             = r.pslverr;
  assign irq                 = r.irq;
  assign tx_out              = r.tx_out;
  assign line_control_enable = r.line_ctl_en;
  assign monitor_enable      = r.monitor_en;
  assign transmission_mode   = r.transmission_mode;
  assign pattern_out_of_lock = r.out_of_lock;
  assign loop_detect_tick    = r.loop_tick;
  assign output_enable       = r.pins_oe;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence strobe_seen_s;
    sec_rise && r.shadow_enable;
  endsequence

  sequence pm_write_s;
    psel && penable && pready && pwrite && !pslverr && paddr == ADDR_PM;
  endsequence

  sequence prbs_write_s;
    psel && penable && pready && pwrite && !pslverr && paddr == ADDR_PRBS;
  endsequence

  shadow_copy_a: assert property (strobe_seen_s |=> r.shadow == $past(live_counts))
    else $error("shadow words do not match counts at strobe");
  shadow_hold_a: assert property (!(sec_rise && r.shadow_enable) |=> $stable(r.shadow))
    else $error("shadow words changed without strobe");
  enable_bit_a: assert property (pm_write_s |=> r.shadow_enable == $past(pwdata[SHADOW_EN_BIT]))
    else $error("shadow enable did not follow the write");
  loop_tick_a: assert property (loop_detect_tick |-> $past(sec_rise) && $past(r.sync2[SY_SEC]))
    else $error("loop detector tick without a strobe");
  line_sel_a: assert property ($past(r.sync2[SY_CFG2]) |-> monitor_enable && !line_control_enable)
    else $error("line control still enabled in monitor mode");
  mode_sel_a: assert property ($past(presetn) |-> transmission_mode == !$past(r.sync2[SY_CFG1]))
    else $error("system mode does not follow its select");
  power_down_a: assert property (!r.sync2[SY_PD] && !extest_active |=> tx_out == '0)
    else $error("transmit pins not low in power down");
  prbs_gate_a: assert property (prbs_write_s ##1 !r.prbs_enable |=> !pattern_out_of_lock)
    else $error("out of lock shown while disabled");
  lock_show_a: assert property ((r.prbs_enable && !r.sync2[SY_CFG1] && !analyzer_in_lock)[*2]
      |=> pattern_out_of_lock)
    else $error("out of lock not shown while unlocked");
  float_out_a: assert property (!r.sync2[SY_FLT] |=> !output_enable)
    else $error("outputs still enabled with float low");
  stat_clear_a: assert property (wr && idx == IDX_STAT && pwdata[EV_SHADOW] && !ev[EV_SHADOW]
      |=> !r.status[EV_SHADOW])
    else $error("status bit not cleared by write one");
endmodule : gcta_top

// File: tb/gcta_board.sv
`timescale 1ns/1ps
module gcta_board (
  // Clock
  input  wire logic pclk,
  // Test port answer
  input  wire logic tdo,
  input  wire logic tdo_oe,
  // Board pins
  output logic      strobe,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  output logic      float_n,
  output logic      scan_en
);
  // ==========================================================================
  // Idle levels; the test clock stands still between frames
  initial begin
    strobe = 1'b0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
    float_n = 1'b1;
    scan_en = 1'b0;
  end
  // Shortened second, a real board gives one per second
  task automatic tick;
    @(posedge pclk) strobe <= 1'b1;
    repeat (4) @(posedge pclk);
    strobe <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : tick
  // One 64 ns test clock; inputs change only while it is low
  task automatic step(input logic m, input logic d, output logic [1:0] o);
    tms <= m;
    tdi <= d;
    #32 tck = 1'b1;
    o = {tdo_oe, tdo};
    #32 tck = 1'b0;
  endtask : step
  // Pulse kept well above the minimum width
  task automatic treset;
    trst_n = 1'b0;
    #20 trst_n = 1'b1;
  endtask : treset
endmodule : gcta_board

// File: tb/gcta_top_bench.sv
`timescale 1ns/1ps
module gcta_top_bench;
  import gcta_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic sys_sel, line_sel, pd_n, lock, strobe, tck, tms, tdi, trst_n, float_n, scan_en;
  logic tdo, tdo_oe, tick_o, ltc_en, mon_en, tmode, pool, oe;
  logic [1:0] o;
  logic [NSH-1:0][CNT_W-1:0] counts;
  gcta_tx_t [NFR-1:0] tx_in, tx_out;
  int err_count = 0, total_checks = 0, ticks = 0;
  gcta_board i_gcta_board (.pclk(pclk), .tdo(tdo), .tdo_oe(tdo_oe), .strobe(strobe), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .float_n(float_n), .scan_en(scan_en));
  gcta_top i_gcta_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .one_second_strobe(strobe), .system_mode_select(sys_sel), .line_control_select(line_sel),
    .protection_power_down_n(pd_n), .global_float_n(float_n), .factory_scan_enable(scan_en),
    .live_counts(counts), .analyzer_in_lock(lock), .tx_in(tx_in), .tx_out(tx_out),
    .line_control_enable(ltc_en), .monitor_enable(mon_en), .transmission_mode(tmode),
    .pattern_out_of_lock(pool), .loop_detect_tick(tick_o), .output_enable(oe), .tck(tck), .tms(tms),
    .tdi(tdi), .test_port_reset_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));
  // ==========================================================================
  // Clock and tick counter
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (tick_o === 1'b1) ticks++;
  // ==========================================================================
  // Shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Master waits for pready; only the watchdog ends a dead wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    x = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    chk(32'(tdo_oe), 32'h0);
    apb(1'b0, 12'h088, 32'h0, r, e);
    chk(r, 32'h6c);
    apb(1'b0, 12'h3fc, 32'h0, r, e);
    chk(32'(e), 32'h1);
    apb(1'b0, 12'h019, 32'h0, r, e);
    chk(32'(e), 32'h1);
  endtask : t_regs
  task automatic t_shadow;
    apb(1'b1, 12'h084, 32'h1, r, e);
    apb(1'b1, ADDR_PM, 32'h8, r, e);
    for (int i = 0; i < NSH; i++) counts[i] <= 16'(32'h1000 + i);
    i_gcta_board.tick;
    chk(32'(irq), 32'h1);
    chk(32'(ticks), 32'h1);
    for (int i = 0; i < NSH; i++) begin
      apb(1'b0, {IDX_SHADOW + 10'(i), 2'b00}, 32'h0, r, e);
      chk(r, 32'h1000 + 32'(i));
    end
    apb(1'b1, ADDR_STAT, 32'h1, r, e);
    cyc(2);
    chk(32'(irq), 32'h0);
    // Shadowing off: counters move on, copies must not
    apb(1'b1, ADDR_PM, 32'h0, r, e);
    counts[0] <= 16'h0bad;
    i_gcta_board.tick;
    apb(1'b0, {IDX_SHADOW, 2'b00}, 32'h0, r, e);
    chk(r, 32'h1000);
    chk(32'(ticks), 32'h2);
  endtask : t_shadow
  task automatic t_cfg;
    for (int k = 0; k < 4; k++) begin
      sys_sel <= k[0];
      line_sel <= k[1];
      cyc(6);
      chk(32'({tmode, ltc_en, mon_en}), 32'({~k[0], ~k[1], k[1]}));
    end
    sys_sel <= 1'b0;
    line_sel <= 1'b0;
  endtask : t_cfg
  task automatic t_pins;
    chk(32'(tx_out), 32'hb6d);
    pd_n <= 1'b0;
    cyc(6);
    chk(32'(tx_out), 32'h0);
    pd_n <= 1'b1;
    i_gcta_board.float_n <= 1'b0;
    cyc(6);
    chk(32'({oe, tx_out}), 32'hb6d);
    i_gcta_board.float_n <= 1'b1;
    cyc(6);
    chk(32'(oe), 32'h1);
  endtask : t_pins
  task automatic t_prbs;
    apb(1'b1, ADDR_PRBS, 32'h20, r, e);
    lock <= 1'b0;
    cyc(4);
    chk(32'(pool), 32'h1);
    lock <= 1'b1;
    cyc(4);
    chk(32'(pool), 32'h0);
    lock <= 1'b0;
    sys_sel <= 1'b1;
    cyc(6);
    chk(32'(pool), 32'h0);
    sys_sel <= 1'b0;
    apb(1'b1, ADDR_PRBS, 32'h0, r, e);
    cyc(4);
    chk(32'(pool), 32'h0);
  endtask : t_prbs
  task automatic t_tap;
    repeat (5) i_gcta_board.step(1'b1, 1'b0, o);
    i_gcta_board.step(1'b0, 1'b0, o);
    i_gcta_board.step(1'b1, 1'b0, o);
    i_gcta_board.step(1'b0, 1'b0, o);
    i_gcta_board.step(1'b0, 1'b0, o);
    i_gcta_board.step(1'b0, 1'b1, o);
    chk(32'(o), 32'h2);
    i_gcta_board.step(1'b0, 1'b0, o);
    chk(32'(o), 32'h3);
    // Load extest through the instruction path; captured 0001 shows first
    repeat (4) i_gcta_board.step(1'b1, 1'b0, o);
    repeat (3) i_gcta_board.step(1'b0, 1'b0, o);
    chk(32'(o), 32'h3);
    repeat (2) i_gcta_board.step(1'b0, 1'b0, o);
    repeat (2) i_gcta_board.step(1'b1, 1'b0, o);
    i_gcta_board.step(1'b0, 1'b0, o);
    cyc(4);
    chk(32'(tx_out), 32'h0);
    i_gcta_board.treset;
    cyc(4);
    chk(32'({tdo_oe, tx_out}), 32'hb6d);
  endtask : t_tap
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sys_sel, line_sel, pd_n, lock} = 4'h3;
    tx_in = 12'hb6d;
    counts = '0;
    cyc(16);
    presetn <= 1'b1;
    cyc(6);
    t_regs;
    t_shadow;
    t_cfg;
    t_pins;
    t_prbs;
    t_tap;
    results;
  end
  initial begin
    #100000;
    err_count++;
    results;
  end
endmodule : gcta_top_bench
